// ### verilog/dlu_pkg.sv
package dlu_pkg;

  // Send command codes from user logic
  localparam logic [1:0] DLU_CMD_NONE = 2'h0;
  localparam logic [1:0] DLU_CMD_PM = 2'h1;
  localparam logic [1:0] DLU_CMD_VSD = 2'h2;
  localparam logic [1:0] DLU_CMD_BAD = 2'h3;

  // Power-management DLLP type codes
  localparam logic [2:0] DLU_PM_ENTER_L1 = 3'h0;
  localparam logic [2:0] DLU_PM_ENTER_L2 = 3'h1;
  localparam logic [2:0] DLU_PM_ASREQ_L1 = 3'h3;
  localparam logic [2:0] DLU_PM_REQ_ACK = 3'h4;

  // Link layer state code from the core
  localparam logic [1:0] DLU_LL_INACTIVE = 2'h0;
  localparam logic [1:0] DLU_LL_INIT = 2'h1;
  localparam logic [1:0] DLU_LL_ACTIVE = 2'h2;

  // Widths and reset values
  localparam int DLU_VSD_W = 24;
  localparam int DLU_RBUF_W = 8;
  localparam logic [2:0] DLU_PM_RESET = 3'h0;
  localparam logic [23:0] DLU_VSD_RESET = 24'h000000;

  // Sender states, one-hot
  typedef enum logic [2:0] {
    DLU_TX_IDLE = 3'b001,
    DLU_TX_PEND = 3'b010,
    DLU_TX_DONE = 3'b100
  } dlu_tx_state_t;

  // One DLLP as passed to or from the link engine
  typedef struct packed {
    logic is_vendor;
    logic [2:0] pm_type;
    logic [DLU_VSD_W-1:0] payload;
  } dlu_dllp_t;

  // Link layer state indicators
  typedef struct packed {
    logic inactive;
    logic initializing;
    logic active;
    logic delivering;
  } dlu_link_t;

endpackage

// ### verilog/dlu_tx_req.sv
`timescale 1ns/1ps
`default_nettype none
module dlu_tx_req
  import dlu_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // User command side
  input wire logic [1:0] cmd_in,
  input wire logic [2:0] pm_type_in,
  input wire logic [DLU_VSD_W-1:0] vsd_in,
  output logic sent_out,
  // Link engine side
  output logic req_out,
  output dlu_dllp_t dllp_out,
  input wire logic gnt_in
);

  dlu_tx_state_t state_q, state_d;
  dlu_dllp_t dllp_q, dllp_d;
  logic sent_q, sent_d;

  // Next state; a finished command must drop to none before the next
  always_comb begin
    state_d = state_q;
    dllp_d = dllp_q;
    sent_d = 1'b0;
    unique case (state_q)
      DLU_TX_IDLE: begin
        // Code 11 is ignored, nothing is latched for it
        if (cmd_in == DLU_CMD_PM || cmd_in == DLU_CMD_VSD) begin
          dllp_d.is_vendor = (cmd_in == DLU_CMD_VSD);
          dllp_d.pm_type = pm_type_in;
          dllp_d.payload = vsd_in;
          state_d = DLU_TX_PEND;
        end
      end
      DLU_TX_PEND: begin
        if (gnt_in) begin
          sent_d = 1'b1;
          state_d = DLU_TX_DONE;
        end
      end
      DLU_TX_DONE: begin
        // Avoids resending a command still held high by the user
        if (cmd_in == DLU_CMD_NONE) begin
          state_d = DLU_TX_IDLE;
        end
      end
      default: state_d = DLU_TX_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= DLU_TX_IDLE;
      dllp_q <= '0;
      sent_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dllp_q <= dllp_d;
      sent_q <= sent_d;
    end
  end

  // Outputs
  assign req_out = (state_q == DLU_TX_PEND);
  assign dllp_out = dllp_q;
  assign sent_out = sent_q;

  a_sent_after_gnt: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    req_out && gnt_in |=> sent_out ##1 !sent_out)
    else $error("sent did not pulse once after grant");

  a_req_holds: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    req_out && !gnt_in |=> req_out && $stable(dllp_out))
    else $error("request dropped or changed before grant");

  a_bad_cmd_ignored: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    state_q == DLU_TX_IDLE && cmd_in == DLU_CMD_BAD |=> !req_out)
    else $error("unused command started a send");

endmodule
`default_nettype wire

// ### verilog/dlu_link_port.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Three separate outputs tell whether the link layer is inactive, initializing or active.
// - The delivering output is high only while active and passing TLPs upward.
// - The sent output pulses once the requested DLLP has really gone out.
// - The received power DLLP type is shown with the same 3-bit coding.
// - The 24-bit payload of a received vendor DLLP is shown on its own output.
// - An active-high valid pulse marks a received DLLP and qualifies type and payload.
// - An output shows when the retry buffer holds no unacknowledged TLPs.
// - An output shows whenever any DLLP is waiting to be sent.
// - An output pulses for each TLP received, as a link activity measure.
module dlu_link_port
  import dlu_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Link layer status from the core
  input wire logic [1:0] dl_state_in,
  input wire logic tl_accepting_in,
  input wire logic [DLU_RBUF_W-1:0] rbuf_count_in,
  input wire logic core_dllp_queued_in,
  input wire logic rx_tlp_good_in,
  // Received DLLP from the core
  input wire logic rx_dllp_val_in,
  input wire dlu_dllp_t rx_dllp_in,
  // Transmit DLLP toward the link engine
  output logic tx_eng_req_out,
  output dlu_dllp_t tx_eng_dllp_out,
  input wire logic tx_eng_gnt_in,
  // User command
  input wire logic [1:0] tx_dllp_cmd_in,
  input wire logic [2:0] tx_pm_type_in,
  input wire logic [DLU_VSD_W-1:0] tx_vsd_data_in,
  output logic tx_dllp_sent_out,
  // User status
  output logic link_layer_inactive_flag_out,
  output logic link_layer_initializing_flag_out,
  output logic link_layer_active_flag_out,
  output logic link_layer_delivering_flag_out,
  // User received DLLP
  output logic [2:0] rx_pm_type_out,
  output logic [DLU_VSD_W-1:0] rx_vsd_data_out,
  output logic rx_dllp_val_out,
  // Power management hints
  output logic tx_rbuf_empty_out,
  output logic tx_dllp_pend_out,
  output logic rx_tlp_rcvd_out
);

  // Decode one state code into a flag; unknown codes read inactive
  function automatic logic dl_is(input logic [1:0] code,
                                 input logic [1:0] want);
    logic known;
    known = (code == DLU_LL_INIT) || (code == DLU_LL_ACTIVE);
    if (want == DLU_LL_INACTIVE) begin
      dl_is = !known;
    end else begin
      dl_is = (code == want);
    end
  endfunction

  dlu_link_t link_q, link_d;
  logic [2:0] rx_type_q, rx_type_d;
  logic [DLU_VSD_W-1:0] rx_vsd_q, rx_vsd_d;
  logic rx_val_q, rx_val_d;
  logic rbuf_empty_q, rbuf_empty_d;
  logic pend_q, pend_d;
  logic tlp_q, tlp_d;
  logic user_req;

  // Request holder between user command and link engine
  dlu_tx_req u_tx_req (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .cmd_in(tx_dllp_cmd_in),
    .pm_type_in(tx_pm_type_in),
    .vsd_in(tx_vsd_data_in),
    .sent_out(tx_dllp_sent_out),
    .req_out(user_req),
    .dllp_out(tx_eng_dllp_out),
    .gnt_in(tx_eng_gnt_in)
  );
  assign tx_eng_req_out = user_req;

  // Link state flags
  always_comb begin
    link_d.inactive = dl_is(dl_state_in, DLU_LL_INACTIVE);
    link_d.initializing = dl_is(dl_state_in, DLU_LL_INIT);
    link_d.active = dl_is(dl_state_in, DLU_LL_ACTIVE);
    // Up only once TLPs actually flow, not on entry to active
    link_d.delivering = link_d.active && tl_accepting_in;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_q <= '{inactive: 1'b1, default: 1'b0};
    end else begin
      link_q <= link_d;
    end
  end

  assign link_layer_inactive_flag_out = link_q.inactive;
  assign link_layer_initializing_flag_out = link_q.initializing;
  assign link_layer_active_flag_out = link_q.active;
  assign link_layer_delivering_flag_out = link_q.delivering;

  // Received DLLP; type holds until the next power DLLP, payload until the next vendor DLLP
  always_comb begin
    rx_type_d = rx_type_q;
    rx_vsd_d = rx_vsd_q;
    rx_val_d = rx_dllp_val_in;
    if (rx_dllp_val_in) begin
      if (rx_dllp_in.is_vendor) begin
        rx_vsd_d = rx_dllp_in.payload;
      end else begin
        rx_type_d = rx_dllp_in.pm_type;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_type_q <= DLU_PM_RESET;
      rx_vsd_q <= DLU_VSD_RESET;
      rx_val_q <= 1'b0;
    end else begin
      rx_type_q <= rx_type_d;
      rx_vsd_q <= rx_vsd_d;
      rx_val_q <= rx_val_d;
    end
  end

  assign rx_pm_type_out = rx_type_q;
  assign rx_vsd_data_out = rx_vsd_q;
  assign rx_dllp_val_out = rx_val_q;

  // Power management hints, registered so they carry no glitches
  always_comb begin
    rbuf_empty_d = (rbuf_count_in == '0);
    // Counts user requests and the core's own ack/flow DLLPs alike
    pend_d = user_req || core_dllp_queued_in;
    tlp_d = rx_tlp_good_in;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rbuf_empty_q <= 1'b1;
      pend_q <= 1'b0;
      tlp_q <= 1'b0;
    end else begin
      rbuf_empty_q <= rbuf_empty_d;
      pend_q <= pend_d;
      tlp_q <= tlp_d;
    end
  end

  assign tx_rbuf_empty_out = rbuf_empty_q;
  assign tx_dllp_pend_out = pend_q;
  assign rx_tlp_rcvd_out = tlp_q;

  a_state_onehot: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    $onehot({link_layer_inactive_flag_out,
             link_layer_initializing_flag_out,
             link_layer_active_flag_out}))
    else $error("link state flags not exactly one");

  a_active_follows: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && dl_state_in == DLU_LL_ACTIVE |=> link_layer_active_flag_out)
    else $error("active flag missed active state");

  a_up_needs_active: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    link_layer_delivering_flag_out |-> link_layer_active_flag_out
      && $past(tl_accepting_in))
    else $error("delivering flag without active and accepting");

  a_rx_pm_type: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && rx_dllp_val_in && !rx_dllp_in.is_vendor |=>
      rx_dllp_val_out && rx_pm_type_out == $past(rx_dllp_in.pm_type))
    else $error("received power type not presented");

  a_rx_vsd_data: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && rx_dllp_val_in && rx_dllp_in.is_vendor |=>
      rx_dllp_val_out && rx_vsd_data_out == $past(rx_dllp_in.payload))
    else $error("received vendor payload not presented");

  a_rbuf_empty: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    // Release edge still shows reset values, so skip it
    $past(resetn_in) |->
      tx_rbuf_empty_out == ($past(rbuf_count_in) == '0))
    else $error("retry empty does not match count");

  a_pend_user: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    tx_eng_req_out ##1 tx_eng_req_out |-> tx_dllp_pend_out)
    else $error("waiting DLLP not shown as pending");

  a_tlp_pulse: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && rx_tlp_good_in |=> rx_tlp_rcvd_out)
    else $error("received TLP not signalled");

  // Pulses must not appear without their cause
  a_rx_val_quiet: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && !rx_dllp_val_in |=> !rx_dllp_val_out)
    else $error("received valid without a DLLP");

  a_tlp_quiet: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    resetn_in && !rx_tlp_good_in |=> !rx_tlp_rcvd_out)
    else $error("TLP pulse without a received TLP");

endmodule
`default_nettype wire

// ### verif/dlu_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
module dlu_eng_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Request from the port, wait chosen by the bench
  input wire logic req_in,
  input wire logic [2:0] dly_in,
  // Transmit done pulse
  output logic gnt_out
);
  logic [2:0] cnt_q;
  // One-cycle grant after a variable wait; slow grants test the hold
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 3'h0;
      gnt_out <= 1'b0;
    end else begin
      gnt_out <= req_in && !gnt_out && (cnt_q >= dly_in);
      cnt_q <= (req_in && !gnt_out) ? cnt_q + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dlu_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] st = 2'h0;
  logic acc = 1'b0, core_q = 1'b0, tlp = 1'b0, rx_val = 1'b0;
  logic [7:0] rbuf = 8'h00;
  dlu_dllp_t rx_d = '0;
  logic [1:0] cmd = 2'h0;
  logic [2:0] pm = 3'h0, dly = 3'h0;
  logic [23:0] vsd = 24'h000000;
  logic req, gnt, sent, f_in, f_ini, f_act, f_del, v_out, r_emp, pend, t_rx;
  dlu_dllp_t eng_d, p_d;
  logic [2:0] pm_out, e_pm;
  logic [23:0] vsd_out, e_vsd;
  logic [1:0] p_st;
  logic p_acc, p_emp, p_q, p_tlp, p_rv, p_req, p_rg, chk_en = 1'b0;
  int errors = 0, samples_checked = 0, seed = 79663, cycles = 0;
  logic [31:0] r, r_vsd;
  dlu_link_port dlu_link_port_inst (.clock_in(clock_in),
    .resetn_in(resetn_in), .dl_state_in(st), .tl_accepting_in(acc),
    .rbuf_count_in(rbuf), .core_dllp_queued_in(core_q),
    .rx_tlp_good_in(tlp), .rx_dllp_val_in(rx_val), .rx_dllp_in(rx_d),
    .tx_eng_req_out(req), .tx_eng_dllp_out(eng_d), .tx_eng_gnt_in(gnt),
    .tx_dllp_cmd_in(cmd), .tx_pm_type_in(pm), .tx_vsd_data_in(vsd),
    .tx_dllp_sent_out(sent), .link_layer_inactive_flag_out(f_in),
    .link_layer_initializing_flag_out(f_ini),
    .link_layer_active_flag_out(f_act),
    .link_layer_delivering_flag_out(f_del), .rx_pm_type_out(pm_out),
    .rx_vsd_data_out(vsd_out), .rx_dllp_val_out(v_out),
    .tx_rbuf_empty_out(r_emp), .tx_dllp_pend_out(pend),
    .rx_tlp_rcvd_out(t_rx));
  dlu_eng_model dlu_eng_model_inst (.clock_in(clock_in),
    .resetn_in(resetn_in), .req_in(req), .dly_in(dly), .gnt_out(gnt));
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  function automatic logic [2:0] pm_code(input int i);
    case (i % 4)
      0: return DLU_PM_ENTER_L1;
      1: return DLU_PM_ENTER_L2;
      2: return DLU_PM_ASREQ_L1;
      default: return DLU_PM_REQ_ACK;
    endcase
  endfunction
  // Flags in order inactive, init, active, delivering; code 3 is inactive
  function automatic logic [3:0] exp_flags(input logic [1:0] s,
                                           input logic a);
    return {s == 2'h0 || s == 2'h3, s == 2'h1, s == 2'h2, s == 2'h2 && a};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Random core-side traffic; count zero often enough to see empty
  always @(posedge clock_in) begin
    r = $random(seed);
    st <= r[1:0];
    acc <= r[2];
    rbuf <= r[4:3] == 2'h0 ? r[12:5] : 8'h00;
    core_q <= r[13] & r[14];
    tlp <= r[15];
    rx_val <= r[16];
    dly <= r[19:17] & {r[20], 2'h3};
    rx_d <= {r[21], pm_code(int'(r[23:22])), r[31:24], r[15:0]};
    cycles++;
    if (cycles == 6000) begin
      errors++;
      stop_test();
    end
  end
  // Outputs lag inputs by one edge; compare against last cycle's inputs
  always @(negedge clock_in) begin
    if (!resetn_in) begin
      e_pm = DLU_PM_RESET;
      e_vsd = DLU_VSD_RESET;
    end
    if (chk_en) begin
      if (p_rv && p_d.is_vendor) e_vsd = p_d.payload;
      else if (p_rv) e_pm = p_d.pm_type;
      check({f_in, f_ini, f_act, f_del}, exp_flags(p_st, p_acc));
      check(pm_out, e_pm);
      check(vsd_out, e_vsd);
      check(v_out, p_rv);
      check(r_emp, p_emp);
      check(pend, p_req | p_q);
      check(t_rx, p_tlp);
      check(sent, p_rg);
    end
    {p_st, p_acc, p_emp, p_q, p_tlp, p_rv} = {st, acc, rbuf == 0, core_q,
                                              tlp, rx_val};
    {p_d, p_req, p_rg} = {rx_d, req, req & gnt};
    chk_en = resetn_in;
  end
  // User side: hold command and data until sent, then return to none
  task automatic send(input logic [1:0] c, input logic [2:0] t,
                      input logic [23:0] v);
    int n;
    @(posedge clock_in);
    cmd <= c;
    pm <= t;
    vsd <= v;
    @(posedge clock_in);
    @(negedge clock_in);
    check(req, 1'b1);
    check(eng_d.is_vendor, c == DLU_CMD_VSD);
    if (c == DLU_CMD_PM) check(eng_d.pm_type, t);
    else check(eng_d.payload, v);
    n = 0;
    while (sent !== 1'b1 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    check(sent, 1'b1);
    @(posedge clock_in);
    cmd <= DLU_CMD_NONE;
    repeat (2) @(posedge clock_in);
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    check({f_in, f_ini, f_act, f_del, r_emp, sent, v_out}, 7'h44);
    @(posedge clock_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r_vsd = $random(seed);
      send(DLU_CMD_PM, pm_code(i), 24'h000000);
      send(DLU_CMD_VSD, 3'h0, i == 0 ? 24'hffffff : r_vsd[23:0]);
    end
    // Unused code must never start a request
    @(posedge clock_in);
    cmd <= DLU_CMD_BAD;
    repeat (6) begin
      @(negedge clock_in);
      check(req, 1'b0);
    end
    @(posedge clock_in);
    cmd <= DLU_CMD_NONE;
    repeat (50) @(posedge clock_in);
    stop_test();
  end
endmodule
`default_nettype wire
